/* File: ppc_port.sv */
// Purpose: Data, direction and control logic of one 8-bit peripheral port.
// Assumes: Host strobes are one cycle long and synchronous.
// Notes: Port A handshakes on data reads, port B on data writes.
//
// Added by the designer: the plain strobed port and the register offsets.
`timescale 1ns/1ps
module ppc_port
#(
   parameter bit IS_B = 1'b0
)
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [7:0] pins_in,
   output logic [7:0] pins_out,
   output logic [7:0] pins_oe,
   input wire logic edge_in1,
   input wire logic hs_in,
   output logic hs_out,
   output logic hs_oe,
   input wire logic wr_data,
   input wire logic wr_dir,
   input wire logic wr_ctrl,
   input wire logic rd_data,
   input wire logic [7:0] wdata,
   output logic [7:0] ctrl_view,
   output logic ev1,
   output logic ev2,
   output logic irq_n
);

   logic [7:0] data_q;
   logic [7:0] dir_q;
   logic [5:0] ctl_q;
   logic flag1_q;
   logic flag2_q;
   logic hs_q;
   logic [1:0] pulse_q;
   logic hit1;
   logic hit2;
   ppc_pkg::ppc_hs_mode_t mode;
   logic access;

   assign mode = ppc_pkg::ppc_hs_mode_t'(ctl_q[ppc_pkg::CTL_C5:ppc_pkg::CTL_C3]);
   // Port A hands off on a data read, port B on a data write.
   assign access = IS_B ? wr_data : rd_data;

   ppc_edge u_e1
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .line_in(edge_in1),
      .pos_edge(ctl_q[ppc_pkg::CTL_EDGE1]),
      .hit(hit1)
   );

   ppc_edge u_e2
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .line_in(hs_in),
      .pos_edge(ctl_q[ppc_pkg::CTL_C4]),
      .hit(hit2)
   );

   // Data, direction and control storage.
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         data_q <= ppc_pkg::RST_BYTE;
         dir_q <= ppc_pkg::RST_BYTE;
         ctl_q <= ppc_pkg::RST_CTRL;
      end
      else
      begin
         if (wr_data)
            data_q <= wdata;
         if (wr_dir)
            dir_q <= wdata; // [RULE1]
         if (wr_ctrl)
            ctl_q <= wdata[5:0];
      end
   end

   // Flags: an edge wins over the clearing data read in the same cycle.
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         flag1_q <= 1'b0;
         flag2_q <= 1'b0;
      end
      else
      begin
         if (hit1)
            flag1_q <= 1'b1; // [RULE3]
         else if (rd_data)
            flag1_q <= 1'b0; // [RULE11]
         if (hit2 && !ctl_q[ppc_pkg::CTL_C5])
            flag2_q <= 1'b1; // [RULE5]
         else if (rd_data || ctl_q[ppc_pkg::CTL_C5])
            flag2_q <= 1'b0; // [RULE11]
      end
   end

   // Handshake output line.
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         hs_q <= 1'b1;
         pulse_q <= 2'h0;
      end
      else
      begin
         pulse_q <= (access && mode == ppc_pkg::PPC_HS_PULSE) ? ppc_pkg::PULSE_CYC
                    : (pulse_q != 2'h0 ? pulse_q - 2'h1 : 2'h0);
         case (mode)
            ppc_pkg::PPC_HS_HANDSHAKE:
            begin
               if (access)
                  hs_q <= 1'b0; // [RULE6] [RULE8]
               else if (hit1)
                  hs_q <= 1'b1; // [RULE6] [RULE8]
            end
            ppc_pkg::PPC_HS_PULSE:
               hs_q <= ~(access || pulse_q > 2'h1); // [RULE7] [RULE9]
            ppc_pkg::PPC_HS_MAN_LOW:
               hs_q <= 1'b0; // [RULE10]
            ppc_pkg::PPC_HS_MAN_HIGH:
               hs_q <= 1'b1; // [RULE10]
            default:
               hs_q <= 1'b1;
         endcase
      end
   end

   // Registered pin drive and interrupt line.
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         pins_out <= 8'h00;
         pins_oe <= 8'h00;
         hs_out <= 1'b1;
         hs_oe <= 1'b0;
         irq_n <= 1'b1;
         ev1 <= 1'b0;
         ev2 <= 1'b0;
      end
      else
      begin
         pins_out <= data_q;
         pins_oe <= dir_q; // [RULE1]
         hs_out <= hs_q;
         hs_oe <= ctl_q[ppc_pkg::CTL_C5]; // [RULE4]
         irq_n <= ~((flag1_q & ctl_q[ppc_pkg::CTL_EN1])
                    | (flag2_q & ctl_q[ppc_pkg::CTL_C3] & ~ctl_q[ppc_pkg::CTL_C5])); // [RULE2] [RULE4]
         ev1 <= hit1;
         ev2 <= hit2 & ~ctl_q[ppc_pkg::CTL_C5];
      end
   end

   assign ctrl_view = {flag1_q, flag2_q, ctl_q};

   a_flag_sets: assert property (@(posedge clk_sys) disable iff (rst)
      hit1 |=> flag1_q) else $error("edge did not set flag one"); // [RULE3]
   a_irq_low: assert property (@(posedge clk_sys) disable iff (rst)
      (flag1_q && ctl_q[0] && $stable(flag1_q)) |=> !irq_n)
      else $error("enabled flag did not pull irq low"); // [RULE2]
   a_hs_input: assert property (@(posedge clk_sys) disable iff (rst)
      !ctl_q[5] |=> !hs_oe) else $error("handshake driven in input mode"); // [RULE4]
   a_flag2_sets: assert property (@(posedge clk_sys) disable iff (rst)
      (hit2 && !ctl_q[5]) |=> flag2_q) else $error("edge did not set flag two"); // [RULE5]
   a_hs_hand_low: assert property (@(posedge clk_sys) disable iff (rst)
      (access && mode == ppc_pkg::PPC_HS_HANDSHAKE) |=> !hs_q)
      else $error("handshake not dropped on access"); // [RULE6]
   a_pulse_one: assert property (@(posedge clk_sys) disable iff (rst)
      (access && mode == ppc_pkg::PPC_HS_PULSE && $stable(ctl_q))
      |=> !hs_q ##1 (hs_q || $past(access)))
      else $error("pulse not one cycle"); // [RULE7]
   a_manual_lvl: assert property (@(posedge clk_sys) disable iff (rst)
      (ctl_q[5] && ctl_q[4]) |=> hs_q == $past(ctl_q[3]))
      else $error("manual level wrong"); // [RULE10]
   a_read_clear: assert property (@(posedge clk_sys) disable iff (rst)
      (rd_data && !hit1) |=> !flag1_q) else $error("read did not clear flag"); // [RULE11]
   a_hand_rise: assert property (@(posedge clk_sys) disable iff (rst)
      (hit1 && !access && mode == ppc_pkg::PPC_HS_HANDSHAKE) |=> hs_q)
      else $error("handshake not raised on edge"); // [RULE8]

endmodule

/* File: ppc_pkg.sv */
// Purpose: Shared constants for the peripheral port handshake control block.
// Assumes: One 10 MHz clock; registers reached over a plain strobe port.
// Notes: Register offsets are byte indices on an 8-bit data path.
package ppc_pkg;

   localparam int ADDR_W = 3;
   localparam int DATA_W = 8;

   // Register offsets.
   localparam logic [2:0] OFF_DATA_A = 3'h0;
   localparam logic [2:0] OFF_DIR_A = 3'h1;
   localparam logic [2:0] OFF_CTRL_A = 3'h2;
   localparam logic [2:0] OFF_DATA_B = 3'h3;
   localparam logic [2:0] OFF_DIR_B = 3'h4;
   localparam logic [2:0] OFF_CTRL_B = 3'h5;
   localparam logic [2:0] OFF_IRQ_STAT = 3'h6;
   localparam logic [2:0] OFF_IRQ_MASK = 3'h7;

   // Control register field positions.
   localparam int CTL_EN1 = 0;
   localparam int CTL_EDGE1 = 1;
   localparam int CTL_C3 = 3;
   localparam int CTL_C4 = 4;
   localparam int CTL_C5 = 5;
   localparam int CTL_FLAG2 = 6;
   localparam int CTL_FLAG1 = 7;

   // Interrupt status layout: one bit per flag.
   localparam int ST_A1 = 0;
   localparam int ST_A2 = 1;
   localparam int ST_B1 = 2;
   localparam int ST_B2 = 3;
   localparam int ST_W = 4;

   // Reset values.
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [5:0] RST_CTRL = 6'h00;
   localparam logic [3:0] RST_MASK = 4'h0;

   // Handshake line modes taken from control bits 5..3.
   typedef enum logic [2:0]
   {
      PPC_HS_IN_NEG_OFF = 3'b000,
      PPC_HS_IN_NEG_ON = 3'b001,
      PPC_HS_IN_POS_OFF = 3'b010,
      PPC_HS_IN_POS_ON = 3'b011,
      PPC_HS_HANDSHAKE = 3'b100,
      PPC_HS_PULSE = 3'b101,
      PPC_HS_MAN_LOW = 3'b110,
      PPC_HS_MAN_HIGH = 3'b111
   } ppc_hs_mode_t;

   // Pulse length in ns and in cycles of the 100 ns clock.
   localparam int CLK_PERIOD_NS = 100;
   localparam int PULSE_NS = 100;
   localparam int PULSE_CYC_I = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] PULSE_CYC = PULSE_CYC_I[1:0];

endpackage

/* File: ppc_edge.sv */
// Purpose: Active-edge detector for one control input line.
// Assumes: Input synchronous to clk_sys.
// Notes: Polarity selects rising (1) or falling (0) as the active edge.
`timescale 1ns/1ps
module ppc_edge
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic line_in,
   input wire logic pos_edge,
   output logic hit
);

   logic prev_q;

   // Previous level, reset low: the falling edge is selected after reset and needs a high first.
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         prev_q <= 1'b0;
      else
         prev_q <= line_in;
   end

   // Edge combinations.
   always_comb
   begin
      if (pos_edge)
         hit = line_in & ~prev_q;
      else
         hit = ~line_in & prev_q;
   end

endmodule

/* File: ppc_top.sv */
// Purpose: Two-port peripheral adapter with edge inputs and handshake lines.
// Assumes: Single 10 MHz clock, synchronous active-high reset.
// Notes: Read data appears one cycle after the read strobe.
//
// Contract
// RULE1 - Every line of both ports is set as input or output by the host.
// RULE2 - Control bit 1 picks edge of line one; bit 0 lets flag 7 pull irq.
// RULE3 - Active edge on line one sets bit 7 whatever bit 0 holds.
// RULE4 - Bit 5 clear makes line two input; bit 4 edge; bit 3 enables irq.
// RULE5 - Active edge on input line two sets bit 6 whatever bit 3 holds.
// RULE6 - Read handshake: line A2 high on edge A1, low on port A data read.
// RULE7 - Pulse mode: line A2 low one cycle after each port A data read.
// RULE8 - Write handshake: line B2 low on port B data write, high on edge B1.
// RULE9 - Pulse mode: line B2 low one cycle after each port B data write.
// RULE10 - Manual mode drives line two to the level of control bit 3.
// RULE11 - Reading port data clears that port's flags, releasing the interrupt.
`timescale 1ns/1ps
module ppc_top
(
   input wire logic clk_sys,
   input wire logic rst,
   input wire logic [2:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [7:0] reg_rdata,
   input wire logic [7:0] port_a_in,
   output logic [7:0] port_a_out,
   output logic [7:0] port_a_oe,
   input wire logic [7:0] port_b_in,
   output logic [7:0] port_b_out,
   output logic [7:0] port_b_oe,
   input wire logic edge_in_a1,
   input wire logic edge_in_b1,
   input wire logic handshake_a2_in,
   output logic handshake_a2_out,
   output logic handshake_a2_oe,
   input wire logic handshake_b2_in,
   output logic handshake_b2_out,
   output logic handshake_b2_oe,
   output logic irq_out_a_n,
   output logic irq_out_b_n,
   output logic irq_q
);

   logic [7:0] ctrl_a;
   logic [7:0] ctrl_b;
   logic [3:0] ev;
   logic [3:0] stat_q;
   logic [3:0] mask_q;
   logic a_rd;
   logic b_rd;

   assign a_rd = reg_rd && reg_addr == ppc_pkg::OFF_DATA_A;
   assign b_rd = reg_rd && reg_addr == ppc_pkg::OFF_DATA_B;

   ppc_port #(.IS_B(1'b0)) u_a
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .pins_in(port_a_in),
      .pins_out(port_a_out),
      .pins_oe(port_a_oe),
      .edge_in1(edge_in_a1),
      .hs_in(handshake_a2_in),
      .hs_out(handshake_a2_out),
      .hs_oe(handshake_a2_oe),
      .wr_data(reg_wr && reg_addr == ppc_pkg::OFF_DATA_A),
      .wr_dir(reg_wr && reg_addr == ppc_pkg::OFF_DIR_A),
      .wr_ctrl(reg_wr && reg_addr == ppc_pkg::OFF_CTRL_A),
      .rd_data(a_rd),
      .wdata(reg_wdata),
      .ctrl_view(ctrl_a),
      .ev1(ev[ppc_pkg::ST_A1]),
      .ev2(ev[ppc_pkg::ST_A2]),
      .irq_n(irq_out_a_n)
   );

   ppc_port #(.IS_B(1'b1)) u_b
   (
      .clk_sys(clk_sys),
      .rst(rst),
      .pins_in(port_b_in),
      .pins_out(port_b_out),
      .pins_oe(port_b_oe),
      .edge_in1(edge_in_b1),
      .hs_in(handshake_b2_in),
      .hs_out(handshake_b2_out),
      .hs_oe(handshake_b2_oe),
      .wr_data(reg_wr && reg_addr == ppc_pkg::OFF_DATA_B),
      .wr_dir(reg_wr && reg_addr == ppc_pkg::OFF_DIR_B),
      .wr_ctrl(reg_wr && reg_addr == ppc_pkg::OFF_CTRL_B),
      .rd_data(b_rd),
      .wdata(reg_wdata),
      .ctrl_view(ctrl_b),
      .ev1(ev[ppc_pkg::ST_B1]),
      .ev2(ev[ppc_pkg::ST_B2]),
      .irq_n(irq_out_b_n)
   );

   // Sticky status, write one to clear; a new event in the same cycle wins.
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         stat_q <= 4'h0;
      else if (reg_wr && reg_addr == ppc_pkg::OFF_IRQ_STAT)
         stat_q <= (stat_q & ~reg_wdata[3:0]) | ev;
      else
         stat_q <= stat_q | ev;
   end

   // Mask register for the combined interrupt.
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         mask_q <= ppc_pkg::RST_MASK;
      else if (reg_wr && reg_addr == ppc_pkg::OFF_IRQ_MASK)
         mask_q <= reg_wdata[3:0];
   end

   // Combined level interrupt, registered.
   always_ff @(posedge clk_sys)
   begin
      if (rst)
         irq_q <= 1'b0;
      else
         irq_q <= |(stat_q & mask_q);
   end

   // Read data valid the cycle after the strobe, zero otherwise.
   always_ff @(posedge clk_sys)
   begin
      if (rst || !reg_rd)
         reg_rdata <= 8'h00;
      else
         case (reg_addr)
            ppc_pkg::OFF_DATA_A: reg_rdata <= port_a_in;
            ppc_pkg::OFF_DIR_A: reg_rdata <= port_a_oe;
            ppc_pkg::OFF_CTRL_A: reg_rdata <= ctrl_a;
            ppc_pkg::OFF_DATA_B: reg_rdata <= (port_b_in & ~port_b_oe) | (port_b_out & port_b_oe);
            ppc_pkg::OFF_DIR_B: reg_rdata <= port_b_oe;
            ppc_pkg::OFF_CTRL_B: reg_rdata <= ctrl_b;
            ppc_pkg::OFF_IRQ_STAT: reg_rdata <= {4'h0, stat_q};
            ppc_pkg::OFF_IRQ_MASK: reg_rdata <= {4'h0, mask_q};
            default: reg_rdata <= 8'h00;
         endcase
   end

endmodule

/* File: ppc_periph.sv */
// Purpose: Peripheral-side model that drives the edge lines, the port pins and line two.
// Assumes: The bench calls drive() from one process at a time.
// Notes: Line two shows the block's level while the block drives it.
`timescale 1ns/1ps
module ppc_periph
(
   input wire logic clk_sys,
   input wire logic hs_a_out,
   input wire logic hs_a_oe,
   input wire logic hs_b_out,
   input wire logic hs_b_oe,
   output logic [7:0] port_a_in,
   output logic [7:0] port_b_in,
   output logic edge_in_a1,
   output logic edge_in_b1,
   output logic handshake_a2_in,
   output logic handshake_b2_in
);
   logic [3:0] line_q = 4'h0;
   logic [15:0] pin_q = 16'h0000;

   // The block wins the shared line while it drives; otherwise our own level shows.
   assign handshake_a2_in = hs_a_oe ? hs_a_out : line_q[2];
   assign handshake_b2_in = hs_b_oe ? hs_b_out : line_q[3];
   assign edge_in_a1 = line_q[0];
   assign edge_in_b1 = line_q[1];
   assign port_a_in = pin_q[7:0];
   assign port_b_in = pin_q[15:8];

   // Levels change just after a rising edge so the block samples them cleanly.
   task automatic drive(input logic [3:0] l, input logic [7:0] a, input logic [7:0] b);
      @(posedge clk_sys);
      line_q <= l;
      pin_q <= {b, a};
   endtask
endmodule

/* File: ppc_top_tb.sv */
// Purpose: Self-checking bench for the two-port handshake adapter.
// Assumes: Read data stands only in the cycle after the read strobe.
// Notes: Expected read values are queued by the driver and checked by a monitor.
`timescale 1ns/1ps
module ppc_top_tb;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic [2:0] reg_addr = 3'h0;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_rdata, port_a_in, port_a_out, port_a_oe, port_b_in, port_b_out, port_b_oe;
   logic edge_in_a1, edge_in_b1, handshake_a2_in, handshake_b2_in;
   logic handshake_a2_out, handshake_a2_oe, handshake_b2_out, handshake_b2_oe;
   logic irq_out_a_n, irq_out_b_n, irq_q, rd_seen = 1'b0;
   logic [7:0] exp_q[$];
   logic [7:0] pa, pb, r;
   logic [3:0] ln = 4'h0;
   int mismatches = 0;
   int compares = 0;
   int cyc = 0;
   int n;
   wire logic [1:0] irqn = {irq_out_b_n, irq_out_a_n};
   wire logic [1:0] hso = {handshake_b2_out, handshake_a2_out};
   wire logic [1:0] hse = {handshake_b2_oe, handshake_a2_oe};

   ppc_top ppc_top_inst (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .port_a_in(port_a_in), .port_a_out(port_a_out), .port_a_oe(port_a_oe),
      .port_b_in(port_b_in), .port_b_out(port_b_out), .port_b_oe(port_b_oe),
      .edge_in_a1(edge_in_a1), .edge_in_b1(edge_in_b1), .handshake_a2_in(handshake_a2_in),
      .handshake_a2_out(handshake_a2_out), .handshake_a2_oe(handshake_a2_oe),
      .handshake_b2_in(handshake_b2_in), .handshake_b2_out(handshake_b2_out),
      .handshake_b2_oe(handshake_b2_oe), .irq_out_a_n(irq_out_a_n),
      .irq_out_b_n(irq_out_b_n), .irq_q(irq_q));

   ppc_periph ppc_periph_inst (.clk_sys(clk_sys), .hs_a_out(handshake_a2_out),
      .hs_a_oe(handshake_a2_oe), .hs_b_out(handshake_b2_out), .hs_b_oe(handshake_b2_oe),
      .port_a_in(port_a_in), .port_b_in(port_b_in), .edge_in_a1(edge_in_a1),
      .edge_in_b1(edge_in_b1), .handshake_a2_in(handshake_a2_in),
      .handshake_b2_in(handshake_b2_in));

   // A 100 ns clock.
   always #50 clk_sys = ~clk_sys;

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic tally_and_finish;
      $display("TB: compares=%0d mismatches=%0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Waits k edges, then half a cycle more, so outputs launched on the last edge have settled.
   task automatic wt(input int k);
      repeat (k) @(posedge clk_sys);
      @(negedge clk_sys);
   endtask

   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk_sys);
      reg_wr <= 1'b0;
   endtask

   // The expectation is queued before the strobe so the monitor always finds it.
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      exp_q.push_back(e);
      @(posedge clk_sys);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk_sys);
      reg_rd <= 1'b0;
   endtask

   // Pulls one line to the inactive level, then makes the chosen edge.
   task automatic act(input int i, input logic pos);
      ln[i] = ~pos;
      ppc_periph_inst.drive(ln, pa, pb);
      wt(2);
      ln[i] = pos;
      ppc_periph_inst.drive(ln, pa, pb);
      wt(4);
   endtask

   task automatic lows(input int p);
      n = 0;
      repeat (6)
      begin
         @(negedge clk_sys);
         if (hso[p] === 1'b0)
            n++;
      end
   endtask

   function automatic logic [2:0] off(input int p, input int k);
      return 3'(p != 0 ? ppc_pkg::OFF_DATA_B + k : ppc_pkg::OFF_DATA_A + k);
   endfunction

   // Read data is looked at in the one cycle where it stands.
   always @(posedge clk_sys)
      rd_seen <= reg_rd;
   always @(negedge clk_sys)
   begin
      if (rd_seen && exp_q.size() > 0)
         chk(reg_rdata, exp_q.pop_front());
   end

   // Cuts a hang short; the tests need well under a thousand cycles.
   always @(posedge clk_sys)
   begin
      cyc <= cyc + 1;
      if (cyc == 3000)
      begin
         mismatches++;
         tally_and_finish();
      end
   end

   initial
   begin
      pa = 8'($urandom(28697));
      pb = 8'($urandom());
      wt(12);
      rst <= 1'b0;
      ppc_periph_inst.drive(ln, pa, pb);
      rd(off(0, 2), 8'h00);
      wt(1);
      chk({irqn, hso, hse, 1'b0, irq_q}, 8'hF0);
      for (int p = 0; p < 2; p++)
      begin
         r = 8'($urandom());
         wr(off(p, 1), r);
         wr(off(p, 0), ~r);
         wt(2);
         chk(p != 0 ? port_b_oe : port_a_oe, r);
         chk(p != 0 ? port_b_out : port_a_out, ~r);
         wr(off(p, 1), 8'h00);
         wr(off(p, 2), 8'h00);
         act(p, 1'b0);
         chk(8'(irqn[p]), 8'h01);
         rd(off(p, 2), 8'h80);
         rd(off(p, 0), p != 0 ? pb : pa);
         rd(off(p, 2), 8'h00);
         wr(off(p, 2), 8'h03);
         act(p, 1'b1);
         chk(8'(irqn[p]), 8'h00);
         rd(off(p, 2), 8'h83);
         rd(off(p, 0), p != 0 ? pb : pa);
         wt(2);
         chk(8'(irqn[p]), 8'h01);
         wr(off(p, 2), 8'h00);
         act(p + 2, 1'b0);
         chk(8'(irqn[p]), 8'h01);
         rd(off(p, 2), 8'h40);
         rd(off(p, 0), p != 0 ? pb : pa);
         wr(off(p, 2), 8'h18);
         act(p + 2, 1'b1);
         chk(8'(irqn[p]), 8'h00);
         rd(off(p, 2), 8'h58);
         rd(off(p, 0), p != 0 ? pb : pa);
         wt(2);
         chk(8'(irqn[p]), 8'h01);
         wr(off(p, 2), 8'h30);
         wt(2);
         chk({hse[p], hso[p]}, 8'h02);
         wr(off(p, 2), 8'h38);
         wt(2);
         chk({hse[p], hso[p]}, 8'h03);
         $display("TB: port %0d edge, input and manual tests done", p);
      end
      wr(ppc_pkg::OFF_IRQ_STAT, 8'h0F);
      wr(ppc_pkg::OFF_IRQ_MASK, 8'h01);
      act(0, 1'b0);
      chk(8'(irq_q), 8'h01);
      rd(ppc_pkg::OFF_IRQ_STAT, 8'h01);
      wr(ppc_pkg::OFF_IRQ_MASK, 8'h00);
      wt(2);
      chk(8'(irq_q), 8'h00);
      wr(ppc_pkg::OFF_IRQ_MASK, 8'h01);
      wt(2);
      chk(8'(irq_q), 8'h01);
      wr(ppc_pkg::OFF_IRQ_STAT, 8'h01);
      wt(2);
      chk(8'(irq_q), 8'h00);
      $display("TB: interrupt status tests done");
      wr(off(0, 2), 8'h20);
      rd(off(0, 0), pa);
      wt(2);
      chk({hse[0], hso[0]}, 8'h02);
      act(0, 1'b0);
      chk({hse[0], hso[0]}, 8'h03);
      wr(off(1, 2), 8'h20);
      wr(off(1, 0), 8'hA5);
      wt(2);
      chk({hse[1], hso[1]}, 8'h02);
      act(1, 1'b0);
      chk({hse[1], hso[1]}, 8'h03);
      wr(off(0, 2), 8'h28);
      rd(off(0, 0), pa);
      lows(0);
      chk(8'(n), 8'h01);
      wr(off(1, 2), 8'h28);
      wr(off(1, 0), 8'h3C);
      lows(1);
      chk(8'(n), 8'h01);
      $display("TB: handshake and pulse tests done");
      tally_and_finish();
   end
endmodule
